// ===== design/pssm_core.sv
// Protocol engine of the password secured serial memory, device side
// How it works
// - Fourteen sectors of eight bytes, sector aligned
// - Writes take eight bytes, reads run on
// - Command prefix, sector, direction; three fixed codes
// - Write password guards writes and changes
// - Two 64-bit passwords, initially zero
// - Bytes of eight bits, ninth clock acknowledges
// - Command byte during write cycle gets no ack
// - Stop before launch abandons write, standby
// - Standby after transaction or failed access
// - Each bad password up to the eighth bumps retry counter
// - Overflow wipes array and both passwords
// - Good password clears counter, grants access
// - Start and stop detected with clock high
// - Bus ignored until a start
// - Start during input restarts command reception
// - Start and stop ignored while outputting
// - Stop during input returns to standby
// - Deselect floats data line, enters standby
// - Reset pulse sends 32 fixed bits if the store is not busy; a second one stops them
// - One bit per clock, stream repeats
// - Poll acked only when done and correct
`timescale 1ns/1ps
module pssm_core
   import pssm_pkg::*;
#(
   parameter int NV_CYCLES = NVW_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic scl,
   input wire logic sda_i,
   input wire logic card_rst,
   output logic sda_o,
   output logic sda_oe
);
   pssm_nv_if nv (); // Link to the store

   logic s_csn; // Synchronised select, active low
   logic s_scl; // Synchronised serial clock
   logic s_sda; // Synchronised data line
   logic s_rst; // Synchronised reset pin
   logic scl_p_q; // Serial clock one cycle back
   logic sda_p_q; // Data line one cycle back
   logic rst_p_q; // Reset pin one cycle back

   pssm_state_e state_q; // Protocol state
   logic [3:0] cnt_q; // Bit position; 8 means the eighth bit is in, 9 is the ack clock
   logic [7:0] shift_q; // Incoming bits
   logic [7:0] tx_q; // Byte being sent
   logic [PWD_W-1:0] stage_q; // Password or write data
   logic [3:0] nbytes_q; // Bytes taken in this phase
   logic [3:0] sector_q; // Addressed sector
   logic [6:0] addr_q; // Next byte to read
   pssm_op_e op_q; // Operation waiting for the password
   logic poll_q; // Password cycle started, poll expected
   logic [4:0] rtr_idx_q; // Position in the reset stream
   logic oe_q; // Pulls the data line low
   logic chk_req_q; // One-cycle check request
   logic wr_req_q; // One-cycle commit request

   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic rst_rise;
   logic outputting;
   logic in_xfer;
   logic cmd_sec;
   logic cmd_ok;
   logic is_poll;
   logic poll_go;
   logic poll_wait;
   pssm_op_e cmd_op;
   logic [PWD_W-1:0] stage_next;
   logic [4:0] rtr_next;
   logic [6:0] addr_next;

   // All four pins cross into the clock domain first
   pssm_sync #(
      .W(4)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({cs_n, scl, sda_i, card_rst}),
      .q({s_csn, s_scl, s_sda, s_rst})
   );

   pssm_nvstore #(
      .NV_CYCLES(NV_CYCLES)
   ) u_store (
      .clk(clk),
      .rst(rst),
      .nv(nv)
   );

   // Previous samples for edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_p_q <= 1'b0;
         sda_p_q <= 1'b1;
         rst_p_q <= 1'b0;
      end else begin
         scl_p_q <= s_scl;
         sda_p_q <= s_sda;
         rst_p_q <= s_rst;
      end
   end

   // Edges of the serial clock; the clock must stay high across both samples
   assign scl_rise = s_scl & ~scl_p_q;
   assign scl_fall = ~s_scl & scl_p_q;
   assign start_ev = s_scl & scl_p_q & sda_p_q & ~s_sda;
   assign stop_ev = s_scl & scl_p_q & ~sda_p_q & s_sda;
   assign rst_rise = s_rst & ~rst_p_q;
   // While the device drives data a master cannot make a start or stop
   assign outputting = (state_q == ST_RDATA) || (state_q == ST_RTR);
   // Idle ignores the bus; the wait state only finishes its ack clock, then lets go
   assign in_xfer = (state_q == ST_CMD) || (state_q == ST_PWD) || (state_q == ST_WDATA) ||
      outputting || (state_q == ST_PWAIT && cnt_q == BIT_END);

   // Command byte decode
   assign cmd_sec = (shift_q[7:5] == CMD_SEC_PFX) && (shift_q[4:1] < N_SECTORS);
   assign cmd_ok = cmd_sec || (shift_q == CMD_CHG_WPW) || (shift_q == CMD_CHG_RPW);
   assign is_poll = shift_q == CMD_POLL;
   assign cmd_op = (shift_q == CMD_CHG_WPW) ? OP_WPW : (shift_q == CMD_CHG_RPW) ? OP_RPW :
      shift_q[0] ? OP_READ : OP_WRITE;
   // Poll answer needs a finished cycle and a matching password
   assign poll_go = poll_q && is_poll && !nv.busy && nv.chk_ok;
   assign poll_wait = poll_q && is_poll && nv.busy;
   assign stage_next = {stage_q[PWD_W-9:0], shift_q};
   assign rtr_next = rtr_idx_q + 5'h01;
   // Reading runs on through the sectors and wraps at the end
   assign addr_next = (addr_q == ADDR_LAST) ? '0 : 7'(addr_q + 7'h01);

   // Store requests come straight from registers
   assign nv.rd_addr = addr_q;
   assign nv.chk_req = chk_req_q;
   assign nv.chk_wr = op_q != OP_READ;
   assign nv.chk_pwd = stage_q;
   assign nv.wr_req = wr_req_q;
   assign nv.wr_op = op_q;
   assign nv.wr_sector = sector_q;
   assign nv.wr_data = stage_q;

   // Open drain: the level driven is always low, only the enable moves
   always_ff @(posedge clk) begin
      if (rst) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end
   assign sda_oe = oe_q;

   // Protocol engine; select, reset pin, start, stop, then clock edges
   always_ff @(posedge clk) begin
      chk_req_q <= 1'b0;
      wr_req_q <= 1'b0;
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         shift_q <= '0;
         tx_q <= '0;
         stage_q <= '0;
         nbytes_q <= '0;
         sector_q <= '0;
         addr_q <= '0;
         op_q <= OP_WRITE;
         poll_q <= 1'b0;
         rtr_idx_q <= '0;
         oe_q <= 1'b0;
      end else if (s_csn) begin
         // Deselected: line released, standby; a running cycle carries on
         state_q <= ST_IDLE;
         oe_q <= 1'b0;
         cnt_q <= '0;
         poll_q <= 1'b0;
      end else if (rst_rise) begin
         if (state_q == ST_RTR) begin
            // A second pulse mid stream stops it with the line released
            state_q <= ST_IDLE;
            oe_q <= 1'b0;
         end else if (!nv.busy) begin
            state_q <= ST_RTR;
            rtr_idx_q <= '0;
            oe_q <= ~RTR_DATA[RTR_TOP];
         end
      end else if (start_ev && !outputting) begin
         // A start outside the output states reopens command reception; a pending poll survives it only from the wait state
         state_q <= ST_CMD;
         cnt_q <= '0;
         oe_q <= 1'b0;
         poll_q <= poll_q && (state_q == ST_PWAIT);
      end else if (stop_ev && !outputting) begin
         // Only a complete eight byte block starts the write cycle
         if (state_q == ST_WDATA && nbytes_q == NB_FULL) begin
            wr_req_q <= 1'b1;
         end
         state_q <= ST_IDLE;
         cnt_q <= '0;
         oe_q <= 1'b0;
         poll_q <= 1'b0;
      end else if (state_q == ST_RTR) begin
         // Next stream bit after each falling clock; wraps after 32
         if (scl_fall) begin
            rtr_idx_q <= rtr_next;
            oe_q <= ~RTR_DATA[5'(RTR_TOP - rtr_next)];
         end
      end else if (scl_rise && in_xfer) begin
         // Sample data bits and the master's ack on the rising clock
         if (cnt_q < BIT_ACK) begin
            shift_q <= {shift_q[6:0], s_sda};
            cnt_q <= cnt_q + 4'h1;
         end else if (cnt_q == BIT_END && state_q == ST_RDATA && s_sda) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
         end
      end else if (scl_fall && in_xfer) begin
         if (cnt_q == BIT_ACK) begin
            // Eighth bit is in: decide the ack for the ninth clock
            cnt_q <= BIT_END;
            case (state_q)
               ST_CMD: begin
                  if (poll_go) begin
                     oe_q <= 1'b1;
                     state_q <= (op_q == OP_READ) ? ST_RDATA : ST_WDATA;
                     nbytes_q <= '0;
                     addr_q <= {sector_q, 3'h0};
                     poll_q <= 1'b0;
                  end else if (poll_wait) begin
                     oe_q <= 1'b0;
                     state_q <= ST_PWAIT;
                  end else if (poll_q && is_poll) begin
                     // Wrong password: refused and back to standby
                     oe_q <= 1'b0;
                     state_q <= ST_IDLE;
                     poll_q <= 1'b0;
                  end else if (nv.busy || !cmd_ok) begin
                     oe_q <= 1'b0;
                     state_q <= ST_IDLE;
                     poll_q <= 1'b0;
                  end else begin
                     oe_q <= 1'b1;
                     op_q <= cmd_op;
                     sector_q <= shift_q[4:1];
                     nbytes_q <= '0;
                     state_q <= ST_PWD;
                     poll_q <= 1'b0;
                  end
               end
               ST_PWD: begin
                  oe_q <= 1'b1;
                  stage_q <= stage_next;
                  nbytes_q <= nbytes_q + 4'h1;
                  // Last password byte: check it and run the cycle
                  if (nbytes_q == NB_PWD_LAST) begin
                     chk_req_q <= 1'b1;
                     state_q <= ST_PWAIT;
                     poll_q <= 1'b1;
                  end
               end
               ST_WDATA: begin
                  // Bytes beyond eight are refused and void the block
                  if (nbytes_q < NB_FULL) begin
                     oe_q <= 1'b1;
                     stage_q <= stage_next;
                     nbytes_q <= nbytes_q + 4'h1;
                  end else begin
                     oe_q <= 1'b0;
                     nbytes_q <= NB_OVER;
                  end
               end
               default: begin
                  // Sending: release the line for the master's ack
                  oe_q <= 1'b0;
               end
            endcase
         end else if (cnt_q == BIT_END) begin
            // Ack clock over: release, or start the next read byte
            cnt_q <= '0;
            if (state_q == ST_RDATA) begin
               tx_q <= nv.rd_data;
               oe_q <= ~nv.rd_data[7];
               addr_q <= addr_next;
            end else begin
               oe_q <= 1'b0;
            end
         end else if (state_q == ST_RDATA) begin
            oe_q <= ~tx_q[3'(BIT_TOP - cnt_q)];
         end
      end
   end

   property p_desel;
      @(posedge clk) disable iff (rst) s_csn |=> !sda_oe && state_q == ST_IDLE;
   endproperty
   a_desel: assert property (p_desel) else $error("select high left line driven");

   property p_busy_nack;
      @(posedge clk) disable iff (rst)
         state_q == ST_CMD && scl_fall && cnt_q == BIT_ACK && !poll_q && nv.busy && !s_csn
         && !rst_rise |=> !sda_oe && state_q == ST_IDLE;
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("command acked while busy");

   property p_rtr_first;
      @(posedge clk) disable iff (rst)
         !s_csn && rst_rise && !nv.busy && state_q != ST_RTR
         |=> state_q == ST_RTR && sda_oe == ~RTR_DATA[RTR_TOP] && rtr_idx_q == '0;
   endproperty
   a_rtr_first: assert property (p_rtr_first) else $error("reset stream did not start");

   property p_rtr_wrap;
      @(posedge clk) disable iff (rst)
         state_q == ST_RTR && rtr_idx_q == RTR_TOP && scl_fall && !s_csn && !rst_rise
         |=> rtr_idx_q == '0 && sda_oe == ~RTR_DATA[RTR_TOP];
   endproperty
   a_rtr_wrap: assert property (p_rtr_wrap) else $error("reset stream did not repeat");

   property p_start_restart;
      @(posedge clk) disable iff (rst)
         start_ev && !s_csn && !rst_rise && (state_q == ST_PWD || state_q == ST_WDATA)
         |=> state_q == ST_CMD && cnt_q == '0 && !sda_oe;
   endproperty
   a_start_restart: assert property (p_start_restart) else $error("start did not restart");

   property p_stop_idle;
      @(posedge clk) disable iff (rst)
         stop_ev && !s_csn && !rst_rise && (state_q == ST_CMD || state_q == ST_PWD)
         |=> state_q == ST_IDLE ##1 !sda_oe;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not reach standby");

   property p_out_ignores;
      @(posedge clk) disable iff (rst)
         state_q == ST_RDATA && (start_ev || stop_ev) && !s_csn && !rst_rise
         |=> state_q != ST_CMD;
   endproperty
   a_out_ignores: assert property (p_out_ignores) else $error("start taken while sending");

   property p_drive_low_clk;
      @(posedge clk) disable iff (rst)
         $changed(sda_oe) && state_q != ST_RTR && $past(state_q) != ST_RTR && !s_csn
         |-> !s_scl;
   endproperty
   a_drive_low_clk: assert property (p_drive_low_clk) else $error("line moved, clock high");

   property p_short_write;
      @(posedge clk) disable iff (rst)
         stop_ev && !s_csn && !rst_rise && state_q == ST_WDATA && nbytes_q != NB_FULL
         |=> !wr_req_q;
   endproperty
   a_short_write: assert property (p_short_write) else $error("short block committed");

   c_rtr: cover property (@(posedge clk) disable iff (rst) state_q == ST_RTR && scl_fall);
   c_read: cover property (@(posedge clk) disable iff (rst) state_q == ST_RDATA);
   c_write: cover property (@(posedge clk) disable iff (rst) wr_req_q);
   c_poll_busy: cover property (@(posedge clk) disable iff (rst) poll_wait && scl_fall);
endmodule // pssm_core

// ===== design/pssm_pkg.sv
// Shared constants and types of the password secured serial memory
package pssm_pkg;
   // Clock and nonvolatile cycle timing
   localparam int CLK_MHZ = 100;
   localparam int NVW_TIME_MS = 10;
   localparam int NVW_CYCLES = NVW_TIME_MS * 1000 * CLK_MHZ;
   localparam int NVW_W = 24;
   // Array geometry
   localparam int MEM_BYTES = 112;
   localparam int SEC_BYTES = 8;
   localparam logic [3:0] N_SECTORS = 4'hE;
   localparam logic [6:0] ADDR_LAST = 7'h6F;
   // Command byte codes
   localparam logic [2:0] CMD_SEC_PFX = 3'h4;
   localparam logic [7:0] CMD_CHG_WPW = 8'hFC;
   localparam logic [7:0] CMD_CHG_RPW = 8'hFE;
   localparam logic [7:0] CMD_POLL = 8'h55;
   // Bit and byte counters
   localparam logic [3:0] BIT_TOP = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_END = 4'h9;
   localparam logic [3:0] NB_PWD_LAST = 4'h7;
   localparam logic [3:0] NB_FULL = 4'h8;
   localparam logic [3:0] NB_OVER = 4'h9;
   // Retry limit and password width
   localparam logic [3:0] RETRY_MAX = 4'h8;
   localparam int PWD_W = 64;
   // Fixed response to reset stream, first byte in the top bits
   localparam logic [31:0] RTR_DATA = 32'h1900AA55;
   localparam logic [4:0] RTR_TOP = 5'h1F;
   // Protocol states
   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_PWD, ST_PWAIT, ST_WDATA, ST_RDATA, ST_RTR
   } pssm_state_e;
   // Pending operation behind a password
   typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_WPW, OP_RPW} pssm_op_e;
endpackage

// ===== design/pssm_nv_if.sv
// Link between protocol engine and nonvolatile store
`timescale 1ns/1ps
interface pssm_nv_if;
   import pssm_pkg::*;
   logic [6:0] rd_addr; // Byte being read out
   logic [7:0] rd_data; // Array byte at rd_addr
   logic chk_req; // Pulse: check password, start cycle
   logic chk_wr; // Check against write password
   logic [PWD_W-1:0] chk_pwd; // Password received
   logic chk_ok; // Last check matched
   logic busy; // Nonvolatile cycle running
   logic wr_req; // Pulse: commit eight bytes
   pssm_op_e wr_op; // Sector or password target
   logic [3:0] wr_sector; // Target sector
   logic [PWD_W-1:0] wr_data; // First byte in top bits
   modport ctrl (output rd_addr, chk_req, chk_wr, chk_pwd, wr_req, wr_op, wr_sector,
      wr_data, input rd_data, chk_ok, busy);
   modport store (input rd_addr, chk_req, chk_wr, chk_pwd, wr_req, wr_op, wr_sector,
      wr_data, output rd_data, chk_ok, busy);
endinterface // pssm_nv_if

// ===== design/pssm_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pssm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q; // First stage, read by q only

   // Both stages clear on reset
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // pssm_sync

// ===== design/pssm_nvstore.sv
// Array, passwords, retry counter and nonvolatile cycle timer
`timescale 1ns/1ps
module pssm_nvstore
   import pssm_pkg::*;
#(
   parameter int NV_CYCLES = NVW_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   pssm_nv_if.store nv
);
   logic [7:0] mem_q [MEM_BYTES]; // Fourteen sectors of eight bytes
   logic [PWD_W-1:0] rpw_q; // Read password
   logic [PWD_W-1:0] wpw_q; // Write password
   logic [3:0] retry_q; // Failed attempts so far
   logic [NVW_W-1:0] timer_q; // Cycles left in the write cycle
   logic ok_q; // Result of last check
   logic pwd_match;
   logic wipe;

   // Sector writes and password changes use the write password
   assign pwd_match = nv.chk_pwd == (nv.chk_wr ? wpw_q : rpw_q);
   // Ninth bad attempt in a row clears everything
   assign wipe = nv.chk_req & ~pwd_match & (retry_q == RETRY_MAX);
   assign nv.busy = timer_q != '0;
   assign nv.rd_data = mem_q[nv.rd_addr];
   assign nv.chk_ok = ok_q;

   // Every check and commit costs one full cycle, which slows guessing
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_q <= '0;
      end else if (nv.chk_req || nv.wr_req) begin
         timer_q <= NVW_W'(NV_CYCLES);
      end else if (nv.busy) begin
         timer_q <= timer_q - 1'b1;
      end
   end

   // Retry counter and check result
   always_ff @(posedge clk) begin
      if (rst) begin
         retry_q <= '0;
         ok_q <= 1'b0;
      end else if (nv.chk_req) begin
         ok_q <= pwd_match;
         if (pwd_match || wipe) begin
            retry_q <= '0;
         end else begin
            retry_q <= retry_q + 1'b1;
         end
      end
   end

   // Passwords start as zeros and return to zeros on a wipe
   always_ff @(posedge clk) begin
      if (rst || wipe) begin
         rpw_q <= '0;
         wpw_q <= '0;
      end else if (nv.wr_req && nv.wr_op == OP_WPW) begin
         wpw_q <= nv.wr_data;
      end else if (nv.wr_req && nv.wr_op == OP_RPW) begin
         rpw_q <= nv.wr_data;
      end
   end

   // A sector commit always lands on the sector's first byte
   always_ff @(posedge clk) begin
      if (rst || wipe) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem_q[i] <= '0;
         end
      end else if (nv.wr_req && nv.wr_op == OP_WRITE) begin
         for (int i = 0; i < SEC_BYTES; i++) begin
            mem_q[{nv.wr_sector, 3'(i)}] <= nv.wr_data[PWD_W-1-8*i -: 8];
         end
      end
   end

   property p_retry_cap;
      @(posedge clk) disable iff (rst) retry_q <= RETRY_MAX;
   endproperty
   a_retry_cap: assert property (p_retry_cap) else $error("retry count past limit");

   property p_wipe;
      @(posedge clk) disable iff (rst)
         wipe |=> (wpw_q == '0) && (rpw_q == '0) && (mem_q[0] == '0) && (retry_q == '0);
   endproperty
   a_wipe: assert property (p_wipe) else $error("overflow did not clear");

   property p_good_resets;
      @(posedge clk) disable iff (rst)
         nv.chk_req && pwd_match |=> ok_q && (retry_q == '0) && nv.busy;
   endproperty
   a_good_resets: assert property (p_good_resets) else $error("good password mishandled");

   c_wipe: cover property (@(posedge clk) disable iff (rst) wipe);
endmodule // pssm_nvstore

// ===== dv/pssm_master.sv
// Host model: drives select, serial clock, data and the reset pulse
`timescale 1ns/1ps
module pssm_master (
   input wire logic clk,
   input wire logic sda_w,
   output logic scl,
   output logic cs_n,
   output logic sda_m,
   output logic card_rst
);
   // Idle: deselected, clock low, data released, reset pin low
   initial begin
      scl = 1'b0;
      cs_n = 1'b1;
      sda_m = 1'b1;
      card_rst = 1'b0;
   end
   // Four system clocks per phase; one more clock per bit gives the 90 ns link period
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   // Data moves one clock after the fall so it never races the clock edge
   task automatic bit_io(input logic b, output logic r);
      @(posedge clk);
      sda_m <= b;
      half();
      scl <= 1'b1;
      half();
      r = sda_w;
      scl <= 1'b0;
   endtask
   // Start when lvl is 0, stop when lvl is 1: data moves with clock high
   task automatic cond(input logic lvl);
      @(posedge clk);
      sda_m <= ~lvl;
      half();
      scl <= 1'b1;
      half();
      sda_m <= lvl;
      half();
      scl <= 1'b0;
   endtask
   // Eight bits MSB first, then the ninth clock carries the acknowledge
   task automatic byte_io(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
      output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(mack, r);
      ack = ~r;
   endtask
   // Select level change, then a settling phase
   task automatic select(input logic v);
      @(posedge clk);
      cs_n <= v;
      half();
   endtask
   // Reset pin is high only for the response pulse
   task automatic rst_pulse();
      @(posedge clk);
      card_rst <= 1'b1;
      half();
      card_rst <= 1'b0;
      half();
   endtask
endmodule // pssm_master

// ===== dv/pssm_core_bench.sv
// Self-checking bench of the protocol engine against the host model
`timescale 1ns/1ps
module pssm_core_bench;
   import pssm_pkg::*;
   localparam int NVC = 200; // Long enough that an early poll lands inside the cycle
   localparam logic [3:0] SEC = 4'hD; // Last legal sector, so reads wrap
   localparam logic [63:0] DAT = 64'h0123456789ABCDEF;
   logic clk;
   logic rst;
   logic scl, cs_n, sda_m, card_rst, sda_o, sda_oe, sda_w;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   // Open drain: device pull-down wins, otherwise master level or pull-up
   assign sda_w = sda_oe ? sda_o : sda_m;
   pssm_master u_pssm_master (
      .clk(clk),
      .sda_w(sda_w),
      .scl(scl),
      .cs_n(cs_n),
      .sda_m(sda_m),
      .card_rst(card_rst)
   );
   pssm_core #(
      .NV_CYCLES(NVC)
   ) u_pssm_core (
      .clk(clk),
      .rst(rst),
      .cs_n(cs_n),
      .scl(scl),
      .sda_i(sda_w),
      .card_rst(card_rst),
      .sda_o(sda_o),
      .sda_oe(sda_oe)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Hang guard: the whole sequence needs well under this many cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         failures++;
         tally_and_finish();
      end
   end
   // Every transaction ends with a stop and a deselect
   task automatic finish_tx();
      u_pssm_master.cond(1'b1);
      u_pssm_master.select(1'b1);
   endtask
   // Command, eight password bytes, an early poll, wait, then the real poll
   task automatic access(input logic [7:0] cmd, input logic [7:0] pw, output logic ok);
      logic [7:0] rx;
      logic a;
      u_pssm_master.select(1'b0);
      u_pssm_master.cond(1'b0);
      u_pssm_master.byte_io(cmd, 1'b1, rx, a);
      check("cmd ack", a, 1'b1);
      for (int i = 0; i < 8; i++) begin
         u_pssm_master.byte_io(pw, 1'b1, rx, a);
         check("pwd ack", a, 1'b1);
      end
      u_pssm_master.cond(1'b0);
      u_pssm_master.byte_io(CMD_POLL, 1'b1, rx, a);
      check("busy poll", a, 1'b0);
      repeat (NVC) @(posedge clk);
      u_pssm_master.cond(1'b0);
      u_pssm_master.byte_io(CMD_POLL, 1'b1, rx, ok);
   endtask
   task automatic do_write();
      logic ok;
      logic a;
      logic [7:0] rx;
      access({CMD_SEC_PFX, SEC, 1'b0}, 8'h00, ok);
      check("write grant", ok, 1'b1);
      for (int i = 7; i >= 0; i--) begin
         u_pssm_master.byte_io(DAT[i*8+:8], 1'b1, rx, a);
         check("data ack", a, 1'b1);
      end
      finish_tx();
      // A command inside the write cycle is refused
      u_pssm_master.select(1'b0);
      u_pssm_master.cond(1'b0);
      u_pssm_master.byte_io({CMD_SEC_PFX, SEC, 1'b1}, 1'b1, rx, a);
      check("busy cmd nack", a, 1'b0);
      finish_tx();
      repeat (NVC + 20) @(posedge clk);
      $display("write done");
   endtask
   // Three data bytes then a stop: the block is dropped, the sector keeps its data
   task automatic t_short();
      logic ok;
      logic a;
      logic [7:0] rx;
      access({CMD_SEC_PFX, SEC, 1'b0}, 8'h00, ok);
      check("short grant", ok, 1'b1);
      repeat (3) begin
         u_pssm_master.byte_io(8'hEE, 1'b1, rx, a);
         check("short ack", a, 1'b1);
      end
      finish_tx();
      $display("short write done");
   endtask
   // Nine bytes: the ninth wraps from the last address to address zero
   task automatic do_read(input logic [7:0] pw, input logic ok_exp, input logic [71:0] exp);
      logic ok;
      logic a;
      logic [7:0] rx;
      logic [71:0] got;
      access({CMD_SEC_PFX, SEC, 1'b1}, pw, ok);
      check("pwd poll", ok, ok_exp);
      if (ok === 1'b1) begin
         for (int i = 8; i >= 0; i--) begin
            u_pssm_master.byte_io(8'hFF, i == 0, rx, a);
            got[i*8+:8] = rx;
         end
         check("read data", got, exp);
      end
      finish_tx();
   endtask
   task automatic t_rtr();
      logic r;
      logic [39:0] got;
      u_pssm_master.select(1'b0);
      u_pssm_master.rst_pulse();
      for (int i = 39; i >= 0; i--) begin
         u_pssm_master.bit_io(1'b1, r);
         got[i] = r;
      end
      check("rtr bits", got, 40'h1900AA5519);
      u_pssm_master.select(1'b1);
      #1;
      check("released", sda_oe, 1'b0);
      $display("reset stream done");
   endtask
   task automatic t_proto();
      logic r;
      logic a;
      logic [7:0] rx;
      u_pssm_master.select(1'b0);
      u_pssm_master.cond(1'b0);
      u_pssm_master.byte_io(8'h9C, 1'b1, rx, a);
      check("illegal nack", a, 1'b0);
      u_pssm_master.cond(1'b0);
      repeat (4) u_pssm_master.bit_io(1'b1, r);
      u_pssm_master.cond(1'b0);
      u_pssm_master.byte_io({CMD_SEC_PFX, SEC, 1'b1}, 1'b1, rx, a);
      check("restart ack", a, 1'b1);
      u_pssm_master.cond(1'b1);
      u_pssm_master.cond(1'b0);
      u_pssm_master.byte_io(CMD_POLL, 1'b1, rx, a);
      check("standby nack", a, 1'b0);
      finish_tx();
      $display("protocol done");
   endtask
   initial begin
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_rtr();
      do_write();
      t_short();
      do_read(8'h00, 1'b1, {DAT, 8'h00});
      t_proto();
      // Eight misses are tolerated and a hit clears the count; the ninth wipes
      for (int r = 0; r < 3; r++) begin
         repeat (r == 2 ? 9 : 8) do_read(8'hA5, 1'b0, 72'h0);
         do_read(8'h00, 1'b1, r == 2 ? 72'h0 : {DAT, 8'h00});
         $display("retry round %0d done", r);
      end
      tally_and_finish();
   end
endmodule // pssm_core_bench
